// [hw/stack_call_pkg.sv]
// Constants for the stack and subroutine support block.
// Assumes a 16-bit word-addressed core view of a 64 KB byte space.
package stack_call_pkg;
  // APB register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SP       = 8'h04;
  localparam logic [7:0] OFS_OVL      = 8'h08;
  localparam logic [7:0] OFS_UNL      = 8'h0c;
  localparam logic [7:0] OFS_CP       = 8'h10;
  localparam logic [7:0] OFS_IP       = 8'h14;
  localparam logic [7:0] OFS_CSP      = 8'h18;
  localparam logic [7:0] OFS_PSW      = 8'h1c;
  localparam logic [7:0] OFS_CMD      = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_STKADDR  = 8'h28;
  localparam logic [7:0] OFS_POPDATA  = 8'h2c;
  // Field positions
  localparam int CTRL_SZ_LSB    = 0;
  localparam int PSW_EOT_BIT    = 0;
  localparam int ST_OVF_BIT     = 0;
  localparam int ST_UNF_BIT     = 1;
  localparam int ST_BTC_BIT     = 2;
  localparam int ST_BRANCH_BIT  = 3;
  localparam int CMD_CODE_LSB   = 0;
  localparam int CMD_COND_BIT   = 8;
  // Reset values and other fixed constants
  localparam logic [2:0]  SZ_RST   = 3'h0;
  localparam logic [2:0]  SZ_LINEAR = 3'h7;
  localparam logic [15:0] SP_RST   = 16'hfc00;
  localparam logic [15:0] OVL_RST  = 16'hfa00;
  localparam logic [15:0] UNL_RST  = 16'hfc00;
  localparam logic [15:0] CP_RST   = 16'hfc00;
  localparam logic [15:0] ZERO16   = 16'h0000;
  localparam logic [15:0] EOT_SENTINEL = 16'h8000;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] LIN_SP_MASK = 16'h0ffe;
  localparam logic [15:0] LIN_SP_BASE = 16'hf000;
  localparam logic [15:0] CIRC_TOP = 16'hfbfe;
  // Command codes written to the command register
  localparam logic [3:0] C_PUSH   = 4'h1;
  localparam logic [3:0] C_POP    = 4'h2;
  localparam logic [3:0] C_ABSOLUTE_CONDITIONAL_CALL  = 4'h3;
  localparam logic [3:0] C_RELATIVE_CALL  = 4'h4;
  localparam logic [3:0] C_CALLS  = 4'h5;
  localparam logic [3:0] C_PUSH_AND_CALL  = 4'h6;
  localparam logic [3:0] C_RET    = 4'h7;
  localparam logic [3:0] C_RETURN_AND_POP   = 4'h8;
  localparam logic [3:0] C_INTERSEGMENT_RETURN   = 4'h9;
  localparam logic [3:0] C_SWITCH_CONTEXT_INSTR   = 4'ha;
  localparam logic [3:0] C_POPCP  = 4'hb;
  localparam logic [3:0] C_CMP    = 4'hc;
  localparam logic [3:0] C_UPUSH  = 4'hd;
  localparam logic [3:0] C_UPOP   = 4'he;
  localparam logic [3:0] C_INDIRECT_CONDITIONAL_CALL  = 4'hf;
  // User stack pointer file: 16 word registers
  localparam int NREG = 16;
  typedef enum logic [2:0] {
    S_IDLE, S_PUSH1, S_PUSH2, S_POP1, S_POP2
  } seq_t;
endpackage : stack_call_pkg

// [hw/stack_call_support.sv]
// Stack, call/return, context switch and table-search flag logic.
// Assumes an APB master drives commands; stack RAM is modelled inside.
//
// Overview of operation
// - Size field 111 selects linear stack over whole on-chip RAM, no wrap.
// - Linear mode bypasses the circular virtual-to-physical transform.
// - Limit pointers bound the linear stack; crossing raises a fatal trap.
// - Linear mode uses only stack pointer bits 11:1 as address, over base f000.
// - No overflow or underflow detection for register-pointer user stacks.
// - Pre-decrement push decrements pointer first; any register allowed.
// - Post-increment pop reads then advances; only R0-R3 unless a move.
// - Context switch loads new bank base on the command write; old base is pushed the next cycle.
// - Popping into the context pointer restores the earlier bank.
// - Calls push the instruction pointer; exit pops it back.
// - Absolute and indirect calls are conditional; relative, intersegment not.
// - Push-and-call pushes operand, then instruction pointer and branches in that cycle.
// - Return-and-pop pops instruction pointer, returning, then pops operand.
// - Intersegment call pushes segment and instruction pointer, two words.
// - Intersegment return restores segment and instruction pointer.
// - Register-memory context switch pushes old pointer, loads operand.
// - System stack grows down; bank entries addressed up from pointer.
// - A single push or pop finishes in one cycle.
// - Status word holds end-of-table flag set by compare against 8000.
// - Branch target cache removes backward-jump delay after first pass.
`default_nettype none
module stack_call_support (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             overflowTrap,
  output logic             underflowTrap
);
  import stack_call_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  logic [2:0]  sizeSel_q;
  logic [15:0] stack_pointer_q, stack_overflow_limit_q;
  logic [15:0] stack_underflow_limit_q, context_pointer_q;
  logic [15:0] instruction_pointer_q, code_segment_pointer_q;
  logic [15:0] processor_status_word_q;
  logic [15:0] operand_q, target_q, popData_q, stkAddr_q;
  logic        ovf_q, unf_q, btcHit_q, branched_q, busy_q;
  logic [15:0] btcTag_q;
  logic        btcValid_q;
  logic [15:0] ram_q [0:2047];
  logic [15:0] gpr_q [0:NREG-1];
  seq_t        seq_q;
  logic [3:0]  cmd_q;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic wrEn, cmdWr, mapped;
  assign wrEn  = psel & penable & pwrite & clkEn;
  assign cmdWr = wrEn & (paddr == OFS_CMD) & ~busy_q;
  assign mapped = (paddr <= OFS_POPDATA) & (paddr[1:0] == 2'b00);

  // ==========================================================
  // Physical stack address
  // ==========================================================
  // Circular sizes splice low SP bits under the fixed top; linear uses SP
  function automatic logic [15:0] physAddr(input logic [15:0] sp,
                                           input logic [2:0] sz);
    logic [15:0] m;
    m = ZERO16;
    case (sz)
      3'h0: m = 16'h01ff;
      3'h1: m = 16'h00ff;
      3'h2: m = 16'h007f;
      3'h3: m = 16'h003f;
      3'h4: m = 16'h03ff;
      default: m = 16'h0000;
    endcase
    if (sz == SZ_LINEAR) begin
      physAddr = LIN_SP_BASE | (sp & LIN_SP_MASK);
    end else begin
      physAddr = (CIRC_TOP & ~m) | (sp & m);
    end
  endfunction : physAddr

  function automatic logic [10:0] ramIdx(input logic [15:0] a);
    ramIdx = a[11:1];
  endfunction : ramIdx

  // Next stack pointer for push and pop; stack grows downward
  logic [15:0] spDec, spInc, pushAddr, popAddr;
  assign spDec    = stack_pointer_q - WORD_STEP;
  assign spInc    = stack_pointer_q + WORD_STEP;
  assign pushAddr = physAddr(spDec, sizeSel_q);
  assign popAddr  = physAddr(stack_pointer_q, sizeSel_q);

  // Decoded command fields
  logic [3:0] code;
  logic       condOk;
  logic [3:0] gIdx;
  assign code   = pwdata[CMD_CODE_LSB +: 4];
  assign condOk = pwdata[CMD_COND_BIT];
  assign gIdx   = pwdata[15:12];

  // ==========================================================
  // Sequencer: every stack step is one cycle
  // ==========================================================
  logic       doPush, doPop;
  logic [15:0] pushVal;
  always_comb begin
    doPush  = 1'b0;
    doPop   = 1'b0;
    pushVal = ZERO16;
    case (seq_q)
      S_PUSH1: begin
        doPush  = 1'b1;
        pushVal = (cmd_q == C_CALLS) ? code_segment_pointer_q : operand_q;
      end
      S_PUSH2: begin
        doPush  = 1'b1;
        pushVal = instruction_pointer_q;
      end
      S_POP1, S_POP2: doPop = 1'b1;
      default: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      seq_q  <= S_IDLE;
      cmd_q  <= 4'h0;
      busy_q <= 1'b0;
    end else if (clkEn) begin
      case (seq_q)
        S_IDLE: if (cmdWr) begin
          cmd_q <= code;
          case (code)
            C_PUSH, C_SWITCH_CONTEXT_INSTR: begin
              seq_q <= S_PUSH1; busy_q <= 1'b1;
            end
            C_ABSOLUTE_CONDITIONAL_CALL, C_INDIRECT_CONDITIONAL_CALL: if (condOk) begin
              seq_q <= S_PUSH2; busy_q <= 1'b1;
            end
            C_RELATIVE_CALL: begin
              seq_q <= S_PUSH2; busy_q <= 1'b1;
            end
            C_PUSH_AND_CALL, C_CALLS: begin
              seq_q <= S_PUSH1; busy_q <= 1'b1;
            end
            C_POP, C_POPCP, C_RET: begin
              seq_q <= S_POP1; busy_q <= 1'b1;
            end
            C_RETURN_AND_POP, C_INTERSEGMENT_RETURN: begin
              seq_q <= S_POP1; busy_q <= 1'b1;
            end
            default: ;
          endcase
        end
        S_PUSH1: begin
          // Calls carry on to push the return address
          if ((cmd_q == C_PUSH_AND_CALL) || (cmd_q == C_CALLS)) begin
            seq_q <= S_PUSH2;
          end else begin
            seq_q <= S_IDLE; busy_q <= 1'b0;
          end
        end
        S_POP1: begin
          if ((cmd_q == C_RETURN_AND_POP) || (cmd_q == C_INTERSEGMENT_RETURN)) begin
            seq_q <= S_POP2;
          end else begin
            seq_q <= S_IDLE; busy_q <= 1'b0;
          end
        end
        default: begin
          seq_q <= S_IDLE; busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Stack RAM and stack pointer
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (clkEn && doPush) begin
      ram_q[ramIdx(pushAddr)] <= pushVal;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stack_pointer_q <= SP_RST;
      popData_q       <= ZERO16;
      stkAddr_q       <= ZERO16;
    end else if (clkEn) begin
      if (doPush) begin
        stack_pointer_q <= spDec;
        stkAddr_q       <= pushAddr;
      end else if (doPop) begin
        stack_pointer_q <= spInc;
        popData_q       <= ram_q[ramIdx(popAddr)];
        stkAddr_q       <= popAddr;
      end else if (wrEn && paddr == OFS_SP && !busy_q) begin
        stack_pointer_q <= pwdata[15:0] & ~16'h0001;
      end else if (cmdWr && code == C_UPUSH) begin
        // User stack accesses report the address they touched
        stkAddr_q <= gpr_q[gIdx] - WORD_STEP;
      end else if (cmdWr && code == C_UPOP
                   && (pwdata[11] || gIdx < 4'h4)) begin
        stkAddr_q <= gpr_q[gIdx];
      end
    end
  end

  // ==========================================================
  // Limit traps: sticky until software writes status
  // ==========================================================
  // Set wins over a clearing write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (clkEn) begin
      if (doPush && (spDec < stack_overflow_limit_q)) begin
        ovf_q <= 1'b1;
      end else if (wrEn && paddr == OFS_STATUS && pwdata[ST_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (doPop && (spInc > stack_underflow_limit_q)) begin
        unf_q <= 1'b1;
      end else if (wrEn && paddr == OFS_STATUS && pwdata[ST_UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sizeSel_q               <= SZ_RST;
      stack_overflow_limit_q  <= OVL_RST;
      stack_underflow_limit_q <= UNL_RST;
    end else if (clkEn && wrEn) begin
      case (paddr)
        OFS_CTRL: sizeSel_q <= pwdata[CTRL_SZ_LSB +: 3];
        OFS_OVL:  stack_overflow_limit_q  <= pwdata[15:0];
        OFS_UNL:  stack_underflow_limit_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Instruction, segment and context pointers
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (rst) begin
      instruction_pointer_q  <= ZERO16;
      code_segment_pointer_q <= ZERO16;
      context_pointer_q      <= CP_RST;
      operand_q              <= ZERO16;
      target_q               <= ZERO16;
    end else if (clkEn) begin
      if (cmdWr) begin
        operand_q <= pwdata[31:16];
        target_q  <= pwdata[31:16];
        if (code == C_SWITCH_CONTEXT_INSTR) begin
          operand_q <= context_pointer_q;
          context_pointer_q <= pwdata[31:16];
        end
      end else if (wrEn && !busy_q) begin
        case (paddr)
          OFS_IP:  instruction_pointer_q  <= pwdata[15:0];
          OFS_CSP: code_segment_pointer_q <= pwdata[15:0];
          OFS_CP:  context_pointer_q      <= pwdata[15:0];
          default: ;
        endcase
      end
      // Branch in the same cycle as the last push
      if (seq_q == S_PUSH2) begin
        instruction_pointer_q <= target_q;
        if (cmd_q == C_CALLS) begin
          code_segment_pointer_q <= operand_q;
        end
      end
      if (seq_q == S_POP1) begin
        if (cmd_q == C_POPCP) begin
          context_pointer_q <= ram_q[ramIdx(popAddr)];
        end else if (cmd_q != C_POP) begin
          instruction_pointer_q <= ram_q[ramIdx(popAddr)];
        end
      end
      if (seq_q == S_POP2 && cmd_q == C_INTERSEGMENT_RETURN) begin
        code_segment_pointer_q <= ram_q[ramIdx(popAddr)];
      end
    end
  end

  // ==========================================================
  // User stack pointers in the register file
  // ==========================================================
  // No limit check here by design; software owns these stacks
  logic       upOk;
  assign upOk = (code == C_UPUSH) || pwdata[11] || (gIdx < 4'h4);
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gUser
      always_ff @(posedge core_clk) begin
        if (rst) begin
          gpr_q[g] <= ZERO16;
        end else if (clkEn && cmdWr && gIdx == 4'(g)) begin
          if (code == C_UPUSH) begin
            gpr_q[g] <= gpr_q[g] - WORD_STEP;
          end else if (code == C_UPOP && upOk) begin
            gpr_q[g] <= gpr_q[g] + WORD_STEP;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Compare, end-of-table flag and branch target cache
  // ==========================================================
  always_ff @(posedge core_clk) begin
    if (rst) begin
      processor_status_word_q <= ZERO16;
      btcTag_q   <= ZERO16;
      btcValid_q <= 1'b0;
      btcHit_q   <= 1'b0;
      branched_q <= 1'b0;
    end else if (clkEn && cmdWr) begin
      if (code == C_CMP) begin
        processor_status_word_q[PSW_EOT_BIT] <=
          (pwdata[31:16] == EOT_SENTINEL);
      end
      if (code == C_RELATIVE_CALL || ((code == C_ABSOLUTE_CONDITIONAL_CALL || code == C_INDIRECT_CONDITIONAL_CALL) && condOk)
          || code == C_PUSH_AND_CALL || code == C_CALLS) begin
        // Repeat of the same target costs no delay after first pass
        btcHit_q   <= btcValid_q && (btcTag_q == pwdata[31:16]);
        btcTag_q   <= pwdata[31:16];
        btcValid_q <= 1'b1;
        branched_q <= 1'b1;
      end else if (code == C_ABSOLUTE_CONDITIONAL_CALL || code == C_INDIRECT_CONDITIONAL_CALL) begin
        branched_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data, ready and trap outputs
  // ==========================================================
  // Zero-wait slave; unmapped offsets answer with an error
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      overflowTrap  <= 1'b0;
      underflowTrap <= 1'b0;
    end else if (clkEn) begin
      overflowTrap  <= ovf_q;
      underflowTrap <= unf_q;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CTRL:    prdata <= {29'h0, sizeSel_q};
          OFS_SP:      prdata <= {16'h0, stack_pointer_q};
          OFS_OVL:     prdata <= {16'h0, stack_overflow_limit_q};
          OFS_UNL:     prdata <= {16'h0, stack_underflow_limit_q};
          OFS_CP:      prdata <= {16'h0, context_pointer_q};
          OFS_IP:      prdata <= {16'h0, instruction_pointer_q};
          OFS_CSP:     prdata <= {16'h0, code_segment_pointer_q};
          OFS_PSW:     prdata <= {16'h0, processor_status_word_q};
          OFS_CMD:     prdata <= {31'h0, busy_q};
          OFS_STATUS:  prdata <= {28'h0, branched_q, btcHit_q, unf_q, ovf_q};
          OFS_STKADDR: prdata <= {16'h0, stkAddr_q};
          OFS_POPDATA: prdata <= {16'h0, popData_q};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule : stack_call_support
`default_nettype wire

// [tb/stack_call_support_properties.sv]
// Port checker for the stack and call support block.
// Assumes one core_clk domain, synchronous active-high rst.
`default_nettype none
module stack_call_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        overflowTrap,
  input wire logic        underflowTrap
);
  import stack_call_pkg::*;
  // ==========================================================
  // Helper terms
  // ==========================================================
  logic setup;
  logic clrOvf;
  logic badOfs;
  // A clear lands one cycle before the trap output follows it
  assign setup  = psel && !penable && clkEn;
  assign clrOvf = psel && penable && pwrite && paddr == OFS_STATUS
                  && pwdata[0];
  assign badOfs = paddr > OFS_POPDATA || paddr[1:0] != 2'b00;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions
  // ==========================================================
  pready_answer_a: assert property (setup |=> pready)
    else $error("no ready in access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  ready_idle_a: assert property (!psel |-> !pready)
    else $error("ready without select");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bad_offset_a: assert property (setup && badOfs |=> pslverr)
    else $error("unmapped offset not refused");
  good_offset_a: assert property (setup && !badOfs |=> !pslverr)
    else $error("mapped offset refused");
  err_read_zero_a: assert property (pready && pslverr && !pwrite
                                    |-> prdata == 32'h0)
    else $error("refused read returned data");
  trap_reset_a: assert property (
    @(posedge core_clk) disable iff (1'b0)
    rst |=> !overflowTrap && !underflowTrap)
    else $error("trap set after reset");
  ovf_sticky_a: assert property (
    overflowTrap && !clrOvf && !$past(clrOvf) |=> overflowTrap)
    else $error("overflow trap dropped without clear");
  // Main scenarios seen at least once
  cover property (setup && pwrite);
  cover property (pready && pslverr);
  cover property ($rose(overflowTrap));
  cover property ($rose(underflowTrap));
endmodule : stack_call_checker
`default_nettype wire

// [tb/stack_call_support_tb_top.sv]
// Self-checking bench for the stack and call support block.
// Assumes a zero-wait APB slave and the package's offsets and codes.
`default_nettype none
module stack_call_support_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import stack_call_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        clkEn    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        overflowTrap;
  logic        underflowTrap;
  logic [31:0] rdat;
  logic        errSeen;
  int          badCount    = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  integer      seed        = 32'h71c6;

  stack_call_support stack_call_support_inst (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .overflowTrap(overflowTrap), .underflowTrap(underflowTrap));

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  always #20 core_clk = ~core_clk;
  // A hung wait counts as a mismatch and closes the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Bus tasks and expectations
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until pready is sampled high at an edge, for at most 16 more edges
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 16) badCount++;
    rdat    = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [15:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {16'h0, e}, rdat);
  endtask : rd

  // Issues one command, then polls busy with a bounded count
  task automatic cmd(input logic [3:0] c, input logic k,
                     input logic [15:0] v);
    int n;
    n = 0;
    apb(1'b1, OFS_CMD, {v, 7'h00, k, 4'h0, c});
    apb(1'b0, OFS_CMD, 32'h0);
    while (rdat[0] !== 1'b0 && n < 8) begin
      n++;
      apb(1'b0, OFS_CMD, 32'h0);
    end
    if (n == 8) badCount++;
  endtask : cmd

  function automatic logic [15:0] linAddr(input logic [15:0] sp);
    return LIN_SP_BASE | (sp & LIN_SP_MASK);
  endfunction : linAddr

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [15:0] a;
    logic [15:0] v;
    logic [15:0] sp;
    logic [3:0]  codes [3];
    logic        k;
    logic        t;
    codes = '{C_ABSOLUTE_CONDITIONAL_CALL, C_INDIRECT_CONDITIONAL_CALL, C_RELATIVE_CALL};
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd("ctrl", OFS_CTRL, ZERO16);
    rd("sp", OFS_SP, SP_RST);
    rd("ovl", OFS_OVL, OVL_RST);
    rd("unl", OFS_UNL, UNL_RST);
    rd("cp", OFS_CP, CP_RST);
    rd("ip", OFS_IP, ZERO16);
    rd("unmapped", 8'h30, ZERO16);
    chk("slverr", 32'h1, {31'h0, errSeen});
    $display("test reset done");
    // Linear stack kept inside on-chip RAM, starting at f7fe
    wr(OFS_CTRL, {13'h0, SZ_LINEAR});
    wr(OFS_OVL, 16'hf600);
    wr(OFS_UNL, 16'hfdfe);
    for (int i = 0; i < 10; i++) begin
      sp = (i == 0) ? 16'hf7fe
                    : 16'hf602 + 16'(({$random(seed)} % 1023) * 2);
      v = 16'($random(seed));
      wr(OFS_SP, sp);
      cmd(C_PUSH, 1'b0, v);
      rd("phys", OFS_STKADDR, linAddr(sp - WORD_STEP));
      rd("sp_push", OFS_SP, sp - WORD_STEP);
      cmd(C_POP, 1'b0, ZERO16);
      rd("pop", OFS_POPDATA, v);
      rd("sp_pop", OFS_SP, sp);
    end
    $display("test linear done");
    wr(OFS_SP, 16'hfd00);
    for (int i = 0; i < 6; i++) begin
      a = 16'($random(seed)) & 16'hfffe;
      v = 16'($random(seed)) & 16'hfffe;
      k = (i >= 3);
      t = k || codes[i % 3] == C_RELATIVE_CALL;
      wr(OFS_IP, a);
      cmd(codes[i % 3], k, v);
      rd("sp_call", OFS_SP, t ? 16'hfcfe : 16'hfd00);
      rd("ip_call", OFS_IP, t ? v : a);
      if (t)
        cmd(C_RET, 1'b0, ZERO16);
      rd("ip_ret", OFS_IP, a);
    end
    // Second call to one target must hit the branch target cache
    cmd(C_RELATIVE_CALL, 1'b0, 16'h0040);
    cmd(C_RET, 1'b0, ZERO16);
    cmd(C_RELATIVE_CALL, 1'b0, 16'h0040);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("btc_hit", 32'hc, rdat & 32'hc);
    cmd(C_RET, 1'b0, ZERO16);
    $display("test calls done");
    wr(OFS_CSP, v);
    wr(OFS_IP, a);
    cmd(C_CALLS, 1'b0, 16'h0012);
    rd("sp_calls", OFS_SP, 16'hfcfc);
    cmd(C_INTERSEGMENT_RETURN, 1'b0, ZERO16);
    rd("ip_intersegment_return", OFS_IP, a);
    rd("csp_intersegment_return", OFS_CSP, v);
    cmd(C_CALLS, 1'b0, 16'h0012);
    cmd(C_POP, 1'b0, ZERO16);
    rd("calls_ip", OFS_POPDATA, a);
    cmd(C_POP, 1'b0, ZERO16);
    rd("calls_csp", OFS_POPDATA, v);
    wr(OFS_IP, a);
    cmd(C_PUSH_AND_CALL, 1'b0, v);
    rd("ip_push_and_call", OFS_IP, v);
    rd("sp_push_and_call", OFS_SP, 16'hfcfc);
    cmd(C_POP, 1'b0, ZERO16);
    rd("push_and_call_ip", OFS_POPDATA, a);
    cmd(C_POP, 1'b0, ZERO16);
    rd("push_and_call_opnd", OFS_POPDATA, v);
    cmd(C_PUSH, 1'b0, v);
    cmd(C_PUSH, 1'b0, a);
    wr(OFS_IP, ZERO16);
    cmd(C_RETURN_AND_POP, 1'b0, ZERO16);
    rd("ip_return_and_pop", OFS_IP, a);
    rd("sp_return_and_pop", OFS_SP, 16'hfd00);
    $display("test segment done");
    wr(OFS_CP, a);
    cmd(C_SWITCH_CONTEXT_INSTR, 1'b0, v);
    rd("cp_switch_context_instr", OFS_CP, v);
    rd("sp_switch_context_instr", OFS_SP, 16'hfcfe);
    cmd(C_POPCP, 1'b0, ZERO16);
    rd("cp_pop", OFS_CP, a);
    cmd(C_CMP, 1'b0, EOT_SENTINEL);
    apb(1'b0, OFS_PSW, 32'h0);
    chk("eot_set", 32'h1, rdat & 32'h1);
    cmd(C_CMP, 1'b0, v & 16'h7fff);
    apb(1'b0, OFS_PSW, 32'h0);
    chk("eot_clr", 32'h0, rdat & 32'h1);
    $display("test context done");
    // Limits hit exactly one step past each boundary
    wr(OFS_OVL, 16'hf700);
    wr(OFS_SP, 16'hf700);
    // Freeze just after the push: the trap output must wait for clkEn
    apb(1'b1, OFS_CMD, {v, 12'h000, C_PUSH});
    clkEn <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("ovf_frozen", 32'h0, {31'h0, overflowTrap});
    clkEn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("ovf_trap", 32'h1, {31'h0, overflowTrap});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("ovf_flag", 32'h1, rdat & 32'h1);
    wr(OFS_STATUS, 16'h0001);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("ovf_clr", 32'h0, {31'h0, overflowTrap});
    wr(OFS_UNL, 16'hfd00);
    wr(OFS_SP, 16'hfd00);
    cmd(C_POP, 1'b0, ZERO16);
    chk("unf_trap", 32'h1, {31'h0, underflowTrap});
    wr(OFS_STATUS, 16'h0002);
    wr(OFS_SP, 16'hf700);
    // Register 0 starts at zero: pre-decrement lands on fffe
    cmd(C_UPUSH, 1'b0, v);
    rd("upush", OFS_STKADDR, 16'hfffe);
    cmd(C_UPOP, 1'b0, ZERO16);
    rd("upop", OFS_STKADDR, 16'hfffe);
    chk("user_ovf", 32'h0, {31'h0, overflowTrap});
    chk("user_unf", 32'h0, {31'h0, underflowTrap});
    $display("test traps done");
    report_and_stop();
  end
endmodule : stack_call_support_tb_top

bind stack_call_support stack_call_checker stack_call_checker_inst (
  .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .overflowTrap(overflowTrap), .underflowTrap(underflowTrap));
`default_nettype wire
